// file: dv/dcff_checker.sv
// concurrent checks on the ports of the dual-clock fifo
`timescale 1ns/1ps
module dcff_checker #(
	parameter int DATA_W = 36,
	parameter bit RESET_INVERTED = 1'b0,
	parameter bit FALL_THROUGH_MODE = 1'b0
) (
	input wire logic presetn,
	input wire logic write_clock,
	input wire logic read_clock,
	input wire logic fifo_reset,
	input wire logic write_enable,
	input wire logic full,
	input wire logic write_overflow_error,
	input wire logic write_side_reset_busy,
	input wire logic read_enable,
	input wire logic [DATA_W-1:0] read_data,
	input wire logic empty,
	input wire logic almost_empty_flag,
	input wire logic read_underflow_error,
	input wire logic read_side_reset_busy
);
	// ----------------------------------------------------------------
	// write side
	// ----------------------------------------------------------------
	a_wbusy_hold: assert property (@(posedge write_clock) disable iff (!presetn)
		(fifo_reset ^ RESET_INVERTED) |=> write_side_reset_busy [*4]) else $error("write busy late");
	a_werr_set: assert property (@(posedge write_clock) disable iff (!presetn)
		write_enable && (full || write_side_reset_busy) |=> write_overflow_error)
		else $error("write error missing");
	a_werr_clear: assert property (@(posedge write_clock) disable iff (!presetn)
		!write_enable || (!full && !write_side_reset_busy) |=> !write_overflow_error)
		else $error("write error stuck");
	// ----------------------------------------------------------------
	// read side
	// ----------------------------------------------------------------
	a_rbusy_follow: assert property (@(posedge read_clock) disable iff (!presetn)
		$rose(write_side_reset_busy) |-> ##[1:8] read_side_reset_busy) else $error("read busy late");
	a_rerr_set: assert property (@(posedge read_clock) disable iff (!presetn)
		read_enable && empty |=> read_underflow_error) else $error("read error missing");
	a_rerr_clear: assert property (@(posedge read_clock) disable iff (!presetn)
		(!read_enable || !empty) && !read_side_reset_busy && !write_side_reset_busy
		|=> !read_underflow_error) else $error("read error stuck");
	a_rdata_hold: assert property (@(posedge read_clock) disable iff (!presetn)
		!(read_enable && !empty) && (!FALL_THROUGH_MODE || !empty) && !read_side_reset_busy
		&& !write_side_reset_busy |=> $stable(read_data)) else $error("read data moved");
	a_reset_empty: assert property (@(posedge read_clock) disable iff (!presetn)
		$fell(read_side_reset_busy) |-> empty && almost_empty_flag) else $error("not empty");
endmodule

bind dcff_fifo dcff_checker #(.DATA_W(DATA_W), .RESET_INVERTED(RESET_INVERTED),
	.FALL_THROUGH_MODE(FALL_THROUGH_MODE)) u_chk (.presetn(presetn),
	.write_clock(write_clock), .read_clock(read_clock), .fifo_reset(fifo_reset),
	.write_enable(write_enable), .full(full), .write_overflow_error(write_overflow_error),
	.write_side_reset_busy(write_side_reset_busy), .read_enable(read_enable),
	.read_data(read_data), .empty(empty), .almost_empty_flag(almost_empty_flag),
	.read_underflow_error(read_underflow_error), .read_side_reset_busy(read_side_reset_busy));

// file: dv/dcff_user.sv
// user logic that writes and reads the fifo on request of the bench
`timescale 1ns/1ps
module dcff_user (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_on,
	input wire logic rd_on,
	input wire logic [35:0] wr_word,
	output logic write_enable,
	output logic [35:0] write_data,
	output logic read_enable
);
	// ----------------------------------------------------------------
	// request registers, changed just after the edge
	// ----------------------------------------------------------------
	// data line inverts its own value every cycle when not writing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_enable <= 1'b0;
			read_enable <= 1'b0;
			write_data <= '0;
		end else begin
			write_enable <= wr_on;
			read_enable <= rd_on;
			write_data <= wr_on ? wr_word : ~write_data;
		end
	end
endmodule

// file: dv/test_dual_clock_fifo_flags.sv
// self-checking bench of the dual-clock fifo against a queue model
`timescale 1ns/1ps
`include "dcff_cfg.svh"
module test_dual_clock_fifo_flags;
	// ----------------------------------------------------------------
	// wiring and model state
	// ----------------------------------------------------------------
	localparam int DEPTH = 16; // words for an address width of 4
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, apb_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rnd, apb_q;
	logic fifo_reset, wr_on, rd_on, write_enable, read_enable, ew, er, pop, push;
	logic [35:0] write_data, read_data, wr_word, exp_word;
	logic full, almost_full_flag, write_overflow_error, write_side_reset_busy;
	logic empty, almost_empty_flag, read_underflow_error, read_side_reset_busy;
	dcff_pkg::dcff_status_t st; // expected status after reset
	int mismatches, checks, ae_lvl, af_lvl;
	logic [35:0] model_q[$]; // words held by the model
	logic full_f, wbusy_f, empty_f, pop_f, push_f; // fall-through twin
	logic [35:0] read_data_f;
	logic [35:0] model_f[$]; // words held for the twin

	// all three domains share pclk; the crossings are still exercised
	dcff_fifo #(.DATA_W(36), .ADDR_W(4)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .write_clock(pclk), .fifo_reset(fifo_reset),
		.write_enable(write_enable), .write_data(write_data), .full(full),
		.almost_full_flag(almost_full_flag), .write_overflow_error(write_overflow_error),
		.write_side_reset_busy(write_side_reset_busy), .read_clock(pclk),
		.read_enable(read_enable), .read_data(read_data), .empty(empty),
		.almost_empty_flag(almost_empty_flag), .read_underflow_error(read_underflow_error),
		.read_side_reset_busy(read_side_reset_busy));
	// twin in fall-through, registered mode with an inverted reset pin, same stimulus
	dcff_fifo #(.DATA_W(36), .ADDR_W(4), .RESET_INVERTED(1'b1), .FALL_THROUGH_MODE(1'b1),
		.REGISTERED_MODE(1'b1)) DUT_FT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(),
		.pready(), .pslverr(), .write_clock(pclk), .fifo_reset(!fifo_reset),
		.write_enable(write_enable), .write_data(write_data), .full(full_f),
		.almost_full_flag(), .write_overflow_error(), .write_side_reset_busy(wbusy_f),
		.read_clock(pclk), .read_enable(read_enable), .read_data(read_data_f),
		.empty(empty_f), .almost_empty_flag(), .read_underflow_error(),
		.read_side_reset_busy());
	dcff_user u_user (.clk(pclk), .rst_n(presetn), .wr_on(wr_on), .rd_on(rd_on),
		.wr_word(wr_word), .write_enable(write_enable), .write_data(write_data),
		.read_enable(read_enable));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	function automatic logic [31:0] next_rnd(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		next_rnd = x ^ (x << 5);
	endfunction

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one apb transfer; starts one edge later so no signal is set twice
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			report_and_stop();
		end
		apb_q = prdata;
		apb_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0000_0000);
		check(36'(apb_q), 36'(exp));
		check(36'(apb_err), 36'(e));
	endtask

	// mode 0 off, 1 on, 2 random, for n cycles
	task automatic traffic(input int mw, input int mr, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			rnd = next_rnd(rnd);
			wr_word <= {rnd[7:4], rnd};
			wr_on <= (mw == 2) ? rnd[0] : (mw == 1);
			rd_on <= (mr == 2) ? rnd[1] : (mr == 1);
		end
		@(posedge pclk);
		wr_on <= 1'b0;
		rd_on <= 1'b0;
	endtask

	task automatic wait_idle;
		int n;
		for (n = 0; n < 100 && (write_side_reset_busy !== 1'b0 || read_side_reset_busy !== 1'b0);
			n++) @(posedge pclk);
		if (n == 100) begin
			mismatches++;
			report_and_stop();
		end
	endtask

	// ----------------------------------------------------------------
	// queue model, compared at every edge
	// ----------------------------------------------------------------
	always @(posedge pclk) begin
		if (presetn && fifo_reset) begin
			model_q.delete();
		end else if (presetn) begin
			ew = write_enable && (full || write_side_reset_busy);
			er = read_enable && empty && !write_side_reset_busy;
			pop = read_enable && !empty && model_q.size() > 0;
			push = write_enable && !full && !write_side_reset_busy;
			if (!write_side_reset_busy && !almost_empty_flag)
				check(36'(model_q.size() >= ae_lvl), 36'd1);
			if (!almost_full_flag) check(36'(model_q.size() <= af_lvl), 36'd1);
			if (pop) exp_word = model_q.pop_front();
			if (push) model_q.push_back(write_data);
			#1;
			if (pop) check(read_data, exp_word);
			check(36'(write_overflow_error), 36'(ew));
			if (!write_side_reset_busy) check(36'(read_underflow_error), 36'(er));
			if (push && model_q.size() == DEPTH) check(36'(full), 36'd1);
			if (pop && !push && model_q.size() == 0) check(36'(empty), 36'd1);
		end
	end

	// twin model: while empty is low the head word must stand on the output
	always @(posedge pclk) begin
		if (presetn && fifo_reset) begin
			model_f.delete();
		end else if (presetn) begin
			pop_f = read_enable && !empty_f && model_f.size() > 0;
			push_f = write_enable && !full_f && !wbusy_f;
			if (pop_f) void'(model_f.pop_front());
			if (push_f) model_f.push_back(write_data);
			#1;
			if (!empty_f) check(read_data_f, model_f[0]);
			if (pop_f && model_f.size() == 0) check(36'(empty_f), 36'd1);
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, fifo_reset, wr_on, rd_on} = '0;
		paddr = '0;
		pwdata = '0;
		wr_word = '0;
		rnd = 32'hca6c5f22;
		{mismatches, checks} = '0;
		ae_lvl = 4;
		af_lvl = 28; // reset level cut to the five level bits of a 16-word fifo
		st = '0;
		st.empty = 1'b1;
		st.almost_empty = 1'b1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(`DCFF_OFF_AE_LEVEL, `DCFF_RST_AE_LEVEL, 1'b0);
		rd(`DCFF_OFF_AF_LEVEL, `DCFF_RST_AF_LEVEL & 32'h0000_001f, 1'b0);
		rd(`DCFF_OFF_STATUS, {24'h00_0000, st}, 1'b0);
		rd(12'h010, 32'h0000_0000, 1'b1);
		apb(1'b1, `DCFF_OFF_AE_LEVEL, 32'h0000_0002);
		apb(1'b1, `DCFF_OFF_AF_LEVEL, 32'h0000_000c);
		ae_lvl = 2;
		af_lvl = 12;
		rd(`DCFF_OFF_AF_LEVEL, 32'h0000_000c, 1'b0);
		traffic(1, 0, DEPTH + 3);
		check(36'(almost_full_flag), 36'd1);
		traffic(0, 1, DEPTH + 6);
		check(36'(almost_empty_flag), 36'd1);
		traffic(2, 2, 300);
		traffic(0, 1, 40);
		check(36'(empty), 36'd1);
		check(36'(empty_f), 36'd1);
		@(posedge pclk);
		fifo_reset <= 1'b1;
		wr_on <= 1'b1;
		rd_on <= 1'b1;
		@(posedge pclk);
		fifo_reset <= 1'b0;
		traffic(1, 1, 3);
		wait_idle();
		check(36'(empty), 36'd1);
		traffic(2, 2, 100);
		traffic(0, 1, 40);
		report_and_stop();
	end
endmodule

// file: rtl/dcff_cfg.svh
// register offsets, reset values and timing counts of the dual-clock fifo
`ifndef DCFF_CFG_SVH
`define DCFF_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the apb)
// ----------------------------------------------------------------
`define DCFF_OFF_AE_LEVEL 12'h000
`define DCFF_OFF_AF_LEVEL 12'h004
`define DCFF_OFF_STATUS 12'h008

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DCFF_RST_AE_LEVEL 32'h0000_0004
`define DCFF_RST_AF_LEVEL 32'h0000_01fc
`define DCFF_RST_DATA 32'h0000_0000

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
// flip-flops in each pointer and level crossing
`define DCFF_SYNC_STAGES 3

`endif

// file: rtl/dcff_fifo.sv
// dual-clock fifo with flags, reset sequence and apb level registers
`timescale 1ns/1ps
`include "dcff_cfg.svh"

module dcff_fifo #(
	parameter int DATA_W = 36,
	parameter int ADDR_W = 9,
	parameter bit RESET_INVERTED = 1'b0,
	parameter bit FALL_THROUGH_MODE = 1'b0,
	parameter bit REGISTERED_MODE = 1'b0,
	parameter bit COMMON_CLOCK = 1'b0,
	parameter int SYNC_STAGES = `DCFF_SYNC_STAGES
) (
	// apb slave, pclk domain
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// write side
	input wire logic write_clock,
	input wire logic fifo_reset,
	input wire logic write_enable,
	input wire logic [DATA_W-1:0] write_data,
	output logic full,
	output logic almost_full_flag,
	output logic write_overflow_error,
	output logic write_side_reset_busy,
	// read side
	input wire logic read_clock,
	input wire logic read_enable,
	output logic [DATA_W-1:0] read_data,
	output logic empty,
	output logic almost_empty_flag,
	output logic read_underflow_error,
	output logic read_side_reset_busy
);

	// ----------------------------------------------------------------
	// local widths and helpers
	// ----------------------------------------------------------------
	localparam int PW = ADDR_W + 1; // pointer width, one wrap bit
	localparam int DEPTH = 1 << ADDR_W;

	// binary to gray
	function automatic logic [PW-1:0] dcff_b2g(input logic [PW-1:0] b);
		dcff_b2g = b ^ (b >> 1);
	endfunction

	// gray to binary
	function automatic logic [PW-1:0] dcff_g2b(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b = '0;
		for (int i = 0; i < PW; i++) begin
			b[i] = ^(g >> i);
		end
		return b;
	endfunction

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem_q [DEPTH]; // word array, written on write clock

	// ----------------------------------------------------------------
	// apb level registers and status readback
	// ----------------------------------------------------------------
	logic [PW-1:0] ae_level_q; // almost_empty_level
	logic [PW-1:0] af_level_q; // almost_full_level
	logic [31:0] prdata_q; // read data, loaded in setup phase
	dcff_pkg::dcff_status_t status_w; // status word gathered from both fifo clocks
	logic [SYNC_STAGES-1:0][7:0] st_sync_q; // status into pclk
	logic apb_wr; // write takes effect
	logic apb_hit; // mapped offset

	// decode the offset
	always_comb begin
		apb_hit = (paddr == `DCFF_OFF_AE_LEVEL) || (paddr == `DCFF_OFF_AF_LEVEL)
			|| (paddr == `DCFF_OFF_STATUS);
	end

	assign apb_wr = psel && penable && pwrite;
	assign pready = 1'b1; // zero wait states
	assign pslverr = psel && penable && !apb_hit; // unmapped offsets error
	assign prdata = prdata_q;

	// level registers, written in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ae_level_q <= PW'(`DCFF_RST_AE_LEVEL);
			af_level_q <= PW'(`DCFF_RST_AF_LEVEL);
		end else if (apb_wr && paddr == `DCFF_OFF_AE_LEVEL) begin
			ae_level_q <= pwdata[PW-1:0];
		end else if (apb_wr && paddr == `DCFF_OFF_AF_LEVEL) begin
			af_level_q <= pwdata[PW-1:0];
		end
	end

	// read data is prepared during setup so it is a flop in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= `DCFF_RST_DATA;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`DCFF_OFF_AE_LEVEL: prdata_q <= 32'(ae_level_q);
				`DCFF_OFF_AF_LEVEL: prdata_q <= 32'(af_level_q);
				`DCFF_OFF_STATUS: prdata_q <= 32'(st_sync_q[SYNC_STAGES-1]);
				default: prdata_q <= `DCFF_RST_DATA;
			endcase
		end
	end

	// status flags come from two other clocks; bits are independent
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_sync_q <= '0;
		end else begin
			st_sync_q <= {st_sync_q[SYNC_STAGES-2:0], status_w};
		end
	end

	// ----------------------------------------------------------------
	// write domain signals
	// ----------------------------------------------------------------
	dcff_pkg::dcff_rst_state_t wr_state_q; // reset sequence
	logic rst_act; // reset input after polarity choice
	logic wr_req; // reset request toward read side
	logic ack_in; // read side acknowledge, seen on write clock
	logic [SYNC_STAGES-1:0] ack_sync_q;
	logic [PW-1:0] wptr_q; // binary write pointer
	logic [PW-1:0] wptr_d;
	logic [PW-1:0] wgray_q; // gray write pointer
	logic [PW-1:0] rg_s; // read gray seen on write clock
	logic [PW-1:0] rgray_q; // gray read pointer, crosses into the write clock
	logic [SYNC_STAGES-1:0][PW-1:0] rg_sync_q;
	logic [PW-1:0] rbin_s_q; // extra stage for the count
	logic [SYNC_STAGES-1:0][PW-1:0] afl_sync_q; // level into write clock
	logic [PW-1:0] wcount; // words as the writer sees them
	logic wr_busy; // write-side reset busy
	logic push; // accepted write
	logic full_q;
	logic full_d;
	logic af_q;
	logic werr_q;

	assign rst_act = fifo_reset ^ RESET_INVERTED;
	assign wr_busy = (wr_state_q != dcff_pkg::dcff_rs_idle);
	assign wr_req = (wr_state_q == dcff_pkg::dcff_rs_hold)
		|| (wr_state_q == dcff_pkg::dcff_rs_wait_ack);

	// reset sequence: hold, hand to the read side, wait for it to finish
	always_ff @(posedge write_clock or negedge presetn) begin
		if (!presetn) begin
			wr_state_q <= dcff_pkg::dcff_rs_idle;
		end else begin
			case (wr_state_q)
				// sampled reset raises busy right after the edge
				dcff_pkg::dcff_rs_idle: begin
					if (rst_act) begin
						wr_state_q <= dcff_pkg::dcff_rs_hold;
					end
				end
				// request already travels while reset is held
				dcff_pkg::dcff_rs_hold: begin
					if (!rst_act) begin
						wr_state_q <= dcff_pkg::dcff_rs_wait_ack;
					end
				end
				// read side has to report its reset
				dcff_pkg::dcff_rs_wait_ack: begin
					if (rst_act) begin
						wr_state_q <= dcff_pkg::dcff_rs_hold;
					end else if (ack_in) begin
						wr_state_q <= dcff_pkg::dcff_rs_wait_drop;
					end
				end
				// read side drops its busy before this side does
				dcff_pkg::dcff_rs_wait_drop: begin
					if (rst_act) begin
						wr_state_q <= dcff_pkg::dcff_rs_hold;
					end else if (!ack_in) begin
						wr_state_q <= dcff_pkg::dcff_rs_idle;
					end
				end
				default: wr_state_q <= dcff_pkg::dcff_rs_idle;
			endcase
		end
	end

	// crossings into the write clock
	always_ff @(posedge write_clock or negedge presetn) begin
		if (!presetn) begin
			ack_sync_q <= '0;
			rg_sync_q <= '0;
			afl_sync_q <= {SYNC_STAGES{PW'(`DCFF_RST_AF_LEVEL)}};
			rbin_s_q <= '0;
		end else begin
			ack_sync_q <= {ack_sync_q[SYNC_STAGES-2:0], read_side_reset_busy};
			rg_sync_q <= {rg_sync_q[SYNC_STAGES-2:0], rgray_q};
			afl_sync_q <= {afl_sync_q[SYNC_STAGES-2:0], af_level_q};
			rbin_s_q <= dcff_g2b(rg_s);
		end
	end

	// accepted writes only; full leaves the pointer alone, busy clears it
	assign push = write_enable && !full_q && !wr_busy;
	assign wptr_d = wptr_q + PW'(push);
	// full when the next pointer catches the read pointer one lap behind
	assign full_d = dcff_b2g(wptr_d)
		== {~rg_s[PW-1:PW-2], rg_s[PW-3:0]};
	assign wcount = wptr_q - rbin_s_q;

	// write pointer, full and almost full
	always_ff @(posedge write_clock or negedge presetn) begin
		if (!presetn) begin
			wptr_q <= '0;
			wgray_q <= '0;
			full_q <= 1'b0;
			af_q <= 1'b0;
		end else if (wr_busy) begin
			wptr_q <= '0;
			wgray_q <= '0;
			full_q <= 1'b0;
			af_q <= 1'b0;
		end else begin
			wptr_q <= wptr_d;
			wgray_q <= dcff_b2g(wptr_d);
			full_q <= full_d;
			af_q <= (wcount >= afl_sync_q[SYNC_STAGES-1]);
		end
	end

	// write error follows its cause each edge, so it clears on its own
	always_ff @(posedge write_clock or negedge presetn) begin
		if (!presetn) begin
			werr_q <= 1'b0;
		end else begin
			werr_q <= write_enable && (full_q || wr_busy);
		end
	end

	// storage write, no reset on the array
	always_ff @(posedge write_clock) begin
		if (push) begin
			mem_q[wptr_q[ADDR_W-1:0]] <= write_data;
		end
	end

	assign full = full_q;
	assign almost_full_flag = af_q;
	assign write_overflow_error = werr_q;
	assign write_side_reset_busy = wr_busy;

	// ----------------------------------------------------------------
	// read domain signals
	// ----------------------------------------------------------------
	logic req_in; // reset request seen on read clock
	logic [SYNC_STAGES-1:0] req_sync_q;
	logic wen_in; // write enable seen on read clock
	logic [SYNC_STAGES-1:0] wen_sync_q;
	logic rd_busy_q;
	logic [PW-1:0] rptr_q; // binary read pointer
	logic [PW-1:0] rptr_d;
	logic [PW-1:0] wg_s; // write gray seen on read clock
	logic [SYNC_STAGES-1:0][PW-1:0] wg_sync_q;
	logic [PW-1:0] wbin_s_q; // extra stage for the count
	logic [SYNC_STAGES-1:0][PW-1:0] ael_sync_q; // level into read clock
	logic [PW-1:0] rcount; // words as the reader sees them
	logic ram_empty; // storage holds nothing unread
	logic rd_ok; // read of a present word
	logic pop; // storage word leaves
	logic valid_q; // fall-through output word present
	logic valid_d;
	logic empty_q;
	logic empty_d;
	logic empty_hold_q; // extra stage for registered mode
	logic ae_q;
	logic rerr_q;
	logic [DATA_W-1:0] rdata_q;

	// crossings into the read clock
	always_ff @(posedge read_clock or negedge presetn) begin
		if (!presetn) begin
			req_sync_q <= '0;
			wen_sync_q <= '0;
			wg_sync_q <= '0;
			ael_sync_q <= {SYNC_STAGES{PW'(`DCFF_RST_AE_LEVEL)}};
			wbin_s_q <= '0;
		end else begin
			req_sync_q <= {req_sync_q[SYNC_STAGES-2:0], wr_req};
			wen_sync_q <= {wen_sync_q[SYNC_STAGES-2:0], write_enable};
			wg_sync_q <= {wg_sync_q[SYNC_STAGES-2:0], wgray_q};
			ael_sync_q <= {ael_sync_q[SYNC_STAGES-2:0], ae_level_q};
			wbin_s_q <= dcff_g2b(wg_s);
		end
	end

	// one clock: request, acknowledge, enable and pointer crossings are bypassed; level crossings stay
	generate
		if (COMMON_CLOCK) begin : g_common
			assign req_in = wr_req;
			assign ack_in = rd_busy_q;
			assign wen_in = write_enable;
			assign wg_s = wgray_q;
			assign rg_s = rgray_q;
		end else begin : g_indep
			assign req_in = req_sync_q[SYNC_STAGES-1];
			assign ack_in = ack_sync_q[SYNC_STAGES-1];
			assign wen_in = wen_sync_q[SYNC_STAGES-1];
			assign wg_s = wg_sync_q[SYNC_STAGES-1];
			assign rg_s = rg_sync_q[SYNC_STAGES-1];
		end
	endgenerate

	// read busy follows the request; it doubles as the acknowledge
	always_ff @(posedge read_clock or negedge presetn) begin
		if (!presetn) begin
			rd_busy_q <= 1'b0;
		end else begin
			rd_busy_q <= req_in;
		end
	end

	assign ram_empty = (rgray_q == wg_s);
	// the visible flag gates reads, so the registered-mode extra empty cycle refuses them too
	assign rd_ok = read_enable && !empty;

	// pop decision and next output state for both read modes
	always_comb begin
		if (FALL_THROUGH_MODE) begin
			// refill the output whenever it is free or being read
			pop = !ram_empty && (!valid_q || rd_ok);
			if (pop) begin
				valid_d = 1'b1;
			end else if (rd_ok) begin
				valid_d = 1'b0;
			end else begin
				valid_d = valid_q;
			end
		end else begin
			pop = rd_ok && !ram_empty;
			valid_d = 1'b0;
		end
		rptr_d = rptr_q + PW'(pop);
		if (FALL_THROUGH_MODE) begin
			empty_d = !valid_d;
		end else begin
			empty_d = (dcff_b2g(rptr_d) == wg_s);
		end
	end

	// stored words including the presented fall-through word
	assign rcount = wbin_s_q - rptr_q + PW'(valid_q);

	// read pointer, output word, empty and almost empty
	always_ff @(posedge read_clock or negedge presetn) begin
		if (!presetn) begin
			rptr_q <= '0;
			rgray_q <= '0;
			valid_q <= 1'b0;
			empty_q <= 1'b1;
			empty_hold_q <= 1'b1;
			ae_q <= 1'b1;
			rdata_q <= '0;
		end else if (req_in || rd_busy_q) begin
			rptr_q <= '0;
			rgray_q <= '0;
			valid_q <= 1'b0;
			empty_q <= 1'b1;
			empty_hold_q <= 1'b1;
			ae_q <= 1'b1;
			rdata_q <= '0;
		end else begin
			rptr_q <= rptr_d;
			rgray_q <= dcff_b2g(rptr_d);
			valid_q <= valid_d;
			empty_q <= empty_d;
			empty_hold_q <= empty_q;
			ae_q <= (rcount <= ael_sync_q[SYNC_STAGES-1]);
			if (pop) begin
				rdata_q <= mem_q[rptr_q[ADDR_W-1:0]];
			end
		end
	end

	// read error follows its cause each edge, so it clears on its own
	always_ff @(posedge read_clock or negedge presetn) begin
		if (!presetn) begin
			rerr_q <= 1'b0;
		end else begin
			rerr_q <= (read_enable && empty)
				|| (wen_in && rd_busy_q);
		end
	end

	assign empty = empty_q || (REGISTERED_MODE && empty_hold_q);
	assign almost_empty_flag = ae_q;
	assign read_underflow_error = rerr_q;
	assign read_side_reset_busy = rd_busy_q;
	assign read_data = rdata_q;

	// status word gathered for the pclk crossing
	assign status_w = '{read_error: rerr_q, write_error: werr_q,
		rd_busy: rd_busy_q, wr_busy: wr_busy, almost_full: af_q,
		full: full_q, almost_empty: ae_q, empty: empty};

endmodule

// file: rtl/dcff_pkg.sv
// types shared by the dual-clock fifo block
package dcff_pkg;

	// ----------------------------------------------------------------
	// write-side reset sequence, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		dcff_rs_idle = 4'b0001,
		dcff_rs_hold = 4'b0010,
		dcff_rs_wait_ack = 4'b0100,
		dcff_rs_wait_drop = 4'b1000
	} dcff_rst_state_t;

	// ----------------------------------------------------------------
	// status word layout, bit 0 first from the bottom
	// ----------------------------------------------------------------
	typedef struct packed {
		logic read_error;
		logic write_error;
		logic rd_busy;
		logic wr_busy;
		logic almost_full;
		logic full;
		logic almost_empty;
		logic empty;
	} dcff_status_t;

endpackage
